/* two_wire_defines.svh */
// Constants shared by both ends of the two-wire serial link.
// What this block does
// - Transmitter changes data only while clock low.
// - Data change with clock high is condition.
// - Start precedes commands; activity before it ignored.
// - Data rising with clock high ends transfer.
// - Stop after read enters standby.
// - Every word is exactly eight bits.
// - Device pulls data low on ninth clock.
// - Host recovers with up to nine clocks, stopping once data reads high, then start.
// - Internal write ends within 5 ms after stop.
// - Device samples on rise, drives on fall.
// - Device only pulls low or releases data.
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define WORD_BITS 8
`define ACK_BIT 8
`define RECOVER_CLOCKS 9
`define SCL_PERIOD_NS 1000
`define SCL_QUARTER_CYCLES ((`SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INTERNAL_WRITE_DURATION_25C_NS 5000000
`define INTERNAL_WRITE_DURATION_FULL_NS 7000000
`define INTERNAL_WRITE_CYCLES (`INTERNAL_WRITE_DURATION_25C_NS / `CLK_PERIOD_NS)
`endif

/* two_wire_pkg.sv */
// Types shared by both ends of the two-wire serial link.
package two_wire_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_RX = 3'h1,
    DEV_ACK = 3'h3,
    DEV_TX = 3'h2,
    DEV_MACK = 3'h6,
    DEV_WAIT = 3'h7
  } dev_state_e;
  typedef enum logic [2:0] {
    HOST_IDLE = 3'h0,
    HOST_START = 3'h1,
    HOST_BYTE = 3'h3,
    HOST_STOP = 3'h2,
    HOST_RECOVER = 3'h6
  } host_state_e;
  typedef enum logic [2:0] {
    CMD_START = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_READ = 3'h2,
    CMD_STOP = 3'h3,
    CMD_RECOVER = 3'h4
  } host_cmd_e;
endpackage

/* two_wire_link_if.sv */
// Wires of the two-wire link, with the open-drain data line resolved.
`timescale 1ns/10ps
`default_nettype none
interface two_wire_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // The pull-up holds the line high unless some driver pulls it low.
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface
`default_nettype wire

/* two_wire_device.sv */
// Device end of the two-wire link: conditions, shifting, acknowledge, write timer.
`timescale 1ns/10ps
`default_nettype none
`include "two_wire_defines.svh"
module two_wire_device #(
  parameter int unsigned WRITE_CYCLES = `INTERNAL_WRITE_CYCLES
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Link side.
  two_wire_link_if.device link,
  // User side: received words.
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  // User side: words to send.
  input wire logic tx_req_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_load_o,
  // User side: status.
  output logic start_o,
  output logic stop_o,
  output logic standby_o,
  output logic write_busy_o
);
  import two_wire_pkg::*;

  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  dev_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic sda_low_r, sda_low_nxt;
  logic seq_tx_r, seq_tx_nxt;
  logic [1:0] rx_words_r, rx_words_nxt;
  logic standby_r, standby_nxt;
  logic busy_r, busy_nxt;
  logic [31:0] wcnt_r, wcnt_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic tx_load_r, tx_load_nxt;
  logic start_r, start_nxt;
  logic stop_r, stop_nxt;
  logic scl_rise, scl_fall, start_det, stop_det;

  // The first stage of each synchroniser feeds only the second one.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= link.scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  // Data moving while the clock stays high is a condition, never a bit.
  assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shreg_nxt = shreg_r;
    sda_low_nxt = sda_low_r;
    seq_tx_nxt = seq_tx_r;
    rx_words_nxt = rx_words_r;
    standby_nxt = standby_r;
    busy_nxt = busy_r;
    wcnt_nxt = wcnt_r;
    rx_data_nxt = rx_data_r;
    rx_valid_nxt = 1'b0;
    tx_load_nxt = 1'b0;
    start_nxt = 1'b0;
    stop_nxt = 1'b0;
    if (busy_r) begin
      if (wcnt_r >= WRITE_CYCLES - 1) begin
        busy_nxt = 1'b0;
      end else begin
        wcnt_nxt = wcnt_r + 32'h1;
      end
    end
    if (start_det) begin
      state_nxt = DEV_RX;
      cnt_nxt = 4'h0;
      sda_low_nxt = 1'b0;
      seq_tx_nxt = 1'b0;
      rx_words_nxt = 2'h0;
      standby_nxt = 1'b0;
      start_nxt = 1'b1;
    end else if (stop_det) begin
      state_nxt = DEV_IDLE;
      sda_low_nxt = 1'b0;
      stop_nxt = 1'b1;
      if (seq_tx_r) begin
        standby_nxt = 1'b1;
      end else if (rx_words_r == 2'h2 && !busy_r) begin
        busy_nxt = 1'b1;
        wcnt_nxt = 32'h0;
      end
    end else begin
      case (state_r)
        DEV_IDLE: begin
          state_nxt = DEV_IDLE;
        end
        DEV_RX: begin
          if (scl_rise) begin
            shreg_nxt = {shreg_r[6:0], sda_s2_r};
            cnt_nxt = cnt_r + 4'h1;
          end
          if (scl_fall && cnt_r == 4'(`WORD_BITS)) begin
            if (busy_r) begin
              // Staying silent lets the host poll until the write is over.
              state_nxt = DEV_WAIT;
            end else begin
              sda_low_nxt = 1'b1;
              state_nxt = DEV_ACK;
              rx_data_nxt = shreg_r;
              rx_valid_nxt = 1'b1;
              if (rx_words_r != 2'h2) begin
                rx_words_nxt = rx_words_r + 2'h1;
              end
            end
          end
        end
        DEV_ACK: begin
          if (scl_fall) begin
            sda_low_nxt = 1'b0;
            cnt_nxt = 4'h0;
            if (tx_req_i) begin
              shreg_nxt = tx_data_i;
              tx_load_nxt = 1'b1;
              sda_low_nxt = !tx_data_i[7];
              seq_tx_nxt = 1'b1;
              state_nxt = DEV_TX;
            end else begin
              state_nxt = DEV_RX;
            end
          end
        end
        DEV_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end
          if (scl_fall) begin
            if (cnt_r == 4'(`WORD_BITS)) begin
              sda_low_nxt = 1'b0;
              state_nxt = DEV_MACK;
            end else begin
              shreg_nxt = {shreg_r[6:0], 1'b0};
              sda_low_nxt = !shreg_r[6];
            end
          end
        end
        DEV_MACK: begin
          if (scl_rise && sda_s2_r) begin
            state_nxt = DEV_WAIT;
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            shreg_nxt = tx_data_i;
            tx_load_nxt = 1'b1;
            sda_low_nxt = !tx_data_i[7];
            state_nxt = DEV_TX;
          end
        end
        DEV_WAIT: begin
          state_nxt = DEV_WAIT;
        end
        default: begin
          state_nxt = DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= DEV_IDLE;
      cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      sda_low_r <= 1'b0;
      seq_tx_r <= 1'b0;
      rx_words_r <= 2'h0;
      standby_r <= 1'b1;
      busy_r <= 1'b0;
      wcnt_r <= 32'h0;
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
      tx_load_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shreg_r <= shreg_nxt;
      sda_low_r <= sda_low_nxt;
      seq_tx_r <= seq_tx_nxt;
      rx_words_r <= rx_words_nxt;
      standby_r <= standby_nxt;
      busy_r <= busy_nxt;
      wcnt_r <= wcnt_nxt;
      rx_data_r <= rx_data_nxt;
      rx_valid_r <= rx_valid_nxt;
      tx_load_r <= tx_load_nxt;
      start_r <= start_nxt;
      stop_r <= stop_nxt;
    end
  end

  // The pin is only ever pulled low or let go; the pull-up makes the high.
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_low_r;
  assign rx_data_o = rx_data_r;
  assign rx_valid_o = rx_valid_r;
  assign tx_load_o = tx_load_r;
  assign start_o = start_r;
  assign stop_o = stop_r;
  assign standby_o = standby_r;
  assign write_busy_o = busy_r;
endmodule
`default_nettype wire

/* two_wire_host.sv */
// Host end of the two-wire link: clock divider and bus command sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "two_wire_defines.svh"
module two_wire_host (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Link side.
  two_wire_link_if.host link,
  // Command port.
  input wire logic cmd_valid_i,
  input wire two_wire_pkg::host_cmd_e cmd_i,
  input wire logic [7:0] wdata_i,
  input wire logic ack_send_i,
  output logic cmd_ready_o,
  // Results.
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic nack_o
);
  import two_wire_pkg::*;

  localparam logic [7:0] QUARTER = 8'(`SCL_QUARTER_CYCLES);

  logic sda_s1_r, sda_s2_r;
  host_state_e state_r, state_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [7:0] qcnt_r, qcnt_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic scl_r, scl_nxt;
  logic sda_low_r, sda_low_nxt;
  logic read_r, read_nxt;
  logic ack_send_r, ack_send_nxt;
  logic found_r, found_nxt;
  logic done_r, done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic nack_r, nack_nxt;
  logic tick;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  assign tick = (qcnt_r == QUARTER - 8'h1);

  // Each bit is four quarter periods: data set while low, rise, sample, fall.
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    qcnt_nxt = tick ? 8'h0 : qcnt_r + 8'h1;
    bit_nxt = bit_r;
    shreg_nxt = shreg_r;
    scl_nxt = scl_r;
    sda_low_nxt = sda_low_r;
    read_nxt = read_r;
    ack_send_nxt = ack_send_r;
    found_nxt = found_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    nack_nxt = nack_r;
    case (state_r)
      HOST_IDLE: begin
        qcnt_nxt = 8'h0;
        phase_nxt = 2'h0;
        bit_nxt = 4'h0;
        if (cmd_valid_i) begin
          scl_nxt = 1'b0;
          sda_low_nxt = 1'b0;
          found_nxt = 1'b0;
          case (cmd_i)
            CMD_START: state_nxt = HOST_START;
            CMD_WRITE, CMD_READ: begin
              state_nxt = HOST_BYTE;
              read_nxt = (cmd_i == CMD_READ);
              ack_send_nxt = ack_send_i;
              shreg_nxt = wdata_i;
              sda_low_nxt = (cmd_i == CMD_WRITE) && !wdata_i[7];
            end
            CMD_STOP: begin
              state_nxt = HOST_STOP;
              sda_low_nxt = 1'b1;
            end
            CMD_RECOVER: state_nxt = HOST_RECOVER;
            default: state_nxt = HOST_IDLE;
          endcase
        end
      end
      HOST_START: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          case (phase_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: sda_low_nxt = 1'b1;
            2'h2: scl_nxt = 1'b0;
            default: begin
              done_nxt = 1'b1;
              state_nxt = HOST_IDLE;
            end
          endcase
        end
      end
      HOST_STOP: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          case (phase_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: sda_low_nxt = 1'b0;
            2'h2: scl_nxt = 1'b1;
            default: begin
              done_nxt = 1'b1;
              state_nxt = HOST_IDLE;
            end
          endcase
        end
      end
      HOST_BYTE: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          case (phase_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: begin
              if (bit_r < 4'(`ACK_BIT)) begin
                shreg_nxt = {shreg_r[6:0], sda_s2_r};
              end else begin
                nack_nxt = sda_s2_r;
              end
            end
            2'h2: scl_nxt = 1'b0;
            default: begin
              bit_nxt = bit_r + 4'h1;
              if (bit_r == 4'(`ACK_BIT)) begin
                sda_low_nxt = 1'b0;
                done_nxt = 1'b1;
                rdata_nxt = shreg_r;
                state_nxt = HOST_IDLE;
              end else if (bit_r == 4'(`ACK_BIT) - 4'h1) begin
                sda_low_nxt = read_r && ack_send_r;
              end else begin
                sda_low_nxt = !read_r && !shreg_r[7];
              end
            end
          endcase
        end
      end
      HOST_RECOVER: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          case (phase_r)
            2'h0: scl_nxt = 1'b1;
            2'h1: found_nxt = sda_s2_r;
            2'h2: begin
              if (found_r) begin
                // Pulling data low while the clock is still high is the start itself.
                // Lowering the clock first would let a sending device take the line back.
                sda_low_nxt = 1'b1;
                phase_nxt = 2'h2;
                state_nxt = HOST_START;
              end else begin
                scl_nxt = 1'b0;
              end
            end
            default: begin
              bit_nxt = bit_r + 4'h1;
              if (bit_r == 4'(`RECOVER_CLOCKS) - 4'h1) begin
                state_nxt = HOST_START;
              end
            end
          endcase
        end
      end
      default: state_nxt = HOST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= HOST_IDLE;
      phase_r <= 2'h0;
      qcnt_r <= 8'h0;
      bit_r <= 4'h0;
      shreg_r <= 8'h00;
      scl_r <= 1'b1;
      sda_low_r <= 1'b0;
      read_r <= 1'b0;
      ack_send_r <= 1'b0;
      found_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      nack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      qcnt_r <= qcnt_nxt;
      bit_r <= bit_nxt;
      shreg_r <= shreg_nxt;
      scl_r <= scl_nxt;
      sda_low_r <= sda_low_nxt;
      read_r <= read_nxt;
      ack_send_r <= ack_send_nxt;
      found_r <= found_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      nack_r <= nack_nxt;
    end
  end

  assign link.scl = scl_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_low_r;
  assign cmd_ready_o = (state_r == HOST_IDLE);
  assign done_o = done_r;
  assign rdata_o = rdata_r;
  assign nack_o = nack_r;
endmodule
`default_nettype wire

/* two_wire_link_chk.sv */
// Assertions on the wires of the two-wire link.
`timescale 1ns/10ps
`default_nettype none
module two_wire_link_chk (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Link wires.
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic scl_r, sda_r, frm_r, frm_nxt, drv_r, drv_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic st, sp;
  assign st = scl && scl_r && sda_r && !sda;
  assign sp = scl && scl_r && !sda_r && sda;
  // The bit count restarts at every start, so a recovery mid-frame never skews it.
  always_comb begin
    frm_nxt = (frm_r || st) && !sp;
    cnt_nxt = cnt_r;
    drv_nxt = drv_r;
    if (st) begin
      cnt_nxt = 4'h0;
    end else if (scl && !scl_r) begin
      cnt_nxt = (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      drv_nxt = (cnt_r == 4'h0) ? dev_sda_oe : (drv_r || (dev_sda_oe && cnt_r != 4'h8));
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      frm_r <= 1'b0;
      cnt_r <= 4'h0;
      drv_r <= 1'b0;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      frm_r <= frm_nxt;
      cnt_r <= cnt_nxt;
      drv_r <= drv_nxt;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_ninth;
    $rose(scl) && cnt_r == 4'h8;
  endsequence
  sequence s_ack_low;
    (dev_sda_oe && !sda) [*8];
  endsequence
  property p_pull_only;
    !(dev_sda_oe && dev_sda_o) && !(host_sda_oe && host_sda_o);
  endproperty
  property p_quiet_idle;
    !frm_r |-> !dev_sda_oe;
  endproperty
  property p_dev_low;
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 3);
  endproperty
  property p_host_hold;
    frm_r && scl && scl_r && !st && !sp |-> $stable(host_sda_oe);
  endproperty
  property p_word_len;
    sp && frm_r |-> cnt_r == 4'h1;
  endproperty
  property p_stop_quiet;
    sp |=> !dev_sda_oe [*8];
  endproperty
  property p_start_quiet;
    st |-> !dev_sda_oe [*4];
  endproperty
  property p_ack_whole;
    s_ninth ##0 dev_sda_oe |-> s_ack_low;
  endproperty
  property p_ack_free;
    s_ninth ##0 (frm_r && !drv_r) |-> !host_sda_oe;
  endproperty
  a_pull_only: assert property (p_pull_only) else $error("sda driven high");
  a_quiet_idle: assert property (p_quiet_idle) else $error("device drove outside frame");
  a_dev_low: assert property (p_dev_low) else $error("device changed sda off low scl");
  a_host_hold: assert property (p_host_hold) else $error("host changed sda scl high");
  a_word_len: assert property (p_word_len) else $error("stop not on word boundary");
  a_stop_quiet: assert property (p_stop_quiet) else $error("device drove after stop");
  a_start_quiet: assert property (p_start_quiet) else $error("device drove at start");
  a_ack_whole: assert property (p_ack_whole) else $error("ack not held");
  a_ack_free: assert property (p_ack_free) else $error("host drove ack slot");
endmodule
`default_nettype wire

/* two_wire_serial_bus_front_end_bench.sv */
// Self-checking bench: host and device ends joined over the link.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module two_wire_serial_bus_front_end_bench;
  import two_wire_pkg::*;
  localparam int unsigned WC = 2000;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0, ack_send_i = 1'b0, tx_req_i = 1'b0;
  host_cmd_e cmd_i = CMD_START;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rx_data_o, rdata_o, tx_data_i, w0, w1;
  logic [7:0] sniff = 8'h00;
  logic rx_valid_o, tx_load_o, start_o, stop_o, standby_o, write_busy_o;
  logic cmd_ready_o, done_o, nack_o;
  logic sniff_ack = 1'b1, scl_q = 1'b1, sda_q = 1'b1;
  int n_fail = 0, comparisons = 0, tx_n = 0, busy_len = 0, bit_n = 0, n0, it;
  int n_start = 0, n_stop = 0, exp_start = 0, exp_stop = 0;
  int seed = 32'h9fe4;
  logic [7:0] rx_q[$];
  always #5 clock_i = ~clock_i;
  two_wire_link_if link ();
  two_wire_device #(.WRITE_CYCLES(WC)) i_two_wire_device (
    .clock_i(clock_i), .rst_i(rst_i), .link(link),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .tx_req_i(tx_req_i), .tx_data_i(tx_data_i), .tx_load_o(tx_load_o),
    .start_o(start_o), .stop_o(stop_o), .standby_o(standby_o), .write_busy_o(write_busy_o));
  two_wire_host i_two_wire_host (
    .clock_i(clock_i), .rst_i(rst_i), .link(link),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .ack_send_i(ack_send_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rdata_o(rdata_o), .nack_o(nack_o));
  two_wire_link_chk i_two_wire_link_chk (
    .clock_i(clock_i), .rst_i(rst_i), .scl(link.scl),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
  // Bit 7 is kept clear so the device visibly drives the first bit of every word it sends.
  function automatic logic [7:0] tx_fn(input int n);
    return 8'((n * 29 + 8'h3c) & 8'h7f);
  endfunction
  assign tx_data_i = tx_fn(tx_n);
  // Wire sniffer: rebuilds each word from the line itself, independent of either end.
  always @(negedge clock_i) begin
    if (link.scl && scl_q && sda_q && !link.sda) begin
      bit_n = 0;
    end else if (link.scl && !scl_q) begin
      if (bit_n < 8) sniff = {sniff[6:0], link.sda};
      else sniff_ack = link.sda;
      bit_n = (bit_n == 8) ? 0 : bit_n + 1;
    end
    scl_q = link.scl;
    sda_q = link.sda;
    if (rx_valid_o) rx_q.push_back(rx_data_o);
    if (tx_load_o) tx_n++;
    if (write_busy_o) busy_len++;
    if (start_o) n_start++;
    if (stop_o) n_stop++;
  end
  task automatic cmd(input host_cmd_e c, input logic [7:0] d, input logic a);
    int i;
    @(negedge clock_i);
    cmd_valid_i = 1'b1;
    cmd_i = c;
    wdata_i = d;
    ack_send_i = a;
    if (c == CMD_START || c == CMD_RECOVER) exp_start++;
    if (c == CMD_STOP) exp_stop++;
    i = 0;
    while (cmd_ready_o !== 1'b1 && i < 3000) begin
      @(negedge clock_i);
      i++;
    end
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && i < 3000) begin
      @(negedge clock_i);
      i++;
    end
    `CHK(i < 3000, 1'b1)
  endtask
  task automatic wait_idle();
    int i;
    i = 0;
    while (write_busy_o !== 1'b0 && i < 4 * WC) begin
      @(negedge clock_i);
      i++;
    end
    `CHK(busy_len > 0 && busy_len <= WC + 4, 1'b1)
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (4) @(negedge clock_i);
    rst_i = 1'b0;
    `CHK({standby_o, write_busy_o}, 2'b10)
    cmd(CMD_RECOVER, 8'h00, 1'b0);
    for (it = 0; it < 4; it++) begin
      w0 = 8'($random(seed));
      w1 = (it == 1) ? 8'h00 : (it == 2) ? 8'hff : 8'($random(seed));
      rx_q.delete();
      if (it != 0) cmd(CMD_START, 8'h00, 1'b0);
      `CHK(standby_o, 1'b0)
      cmd(CMD_WRITE, w0, 1'b0);
      `CHK({sniff, sniff_ack, nack_o}, {w0, 2'b00})
      cmd(CMD_WRITE, w1, 1'b0);
      `CHK({rx_q.size() == 2, nack_o}, 2'b10)
      `CHK({rx_q[0], rx_q[1]}, {w0, w1})
      busy_len = 0;
      cmd(CMD_STOP, 8'h00, 1'b0);
      repeat (5) @(negedge clock_i);
      `CHK({write_busy_o, link.sda, link.scl}, 3'b111)
      if (it == 0) begin
        cmd(CMD_START, 8'h00, 1'b0);
        cmd(CMD_WRITE, 8'($random(seed)), 1'b0);
        `CHK({nack_o, sniff_ack, write_busy_o}, 3'b111)
        cmd(CMD_STOP, 8'h00, 1'b0);
      end
      wait_idle();
    end
    cmd(CMD_START, 8'h00, 1'b0);
    tx_req_i = 1'b1;
    n0 = tx_n;
    cmd(CMD_WRITE, 8'($random(seed)), 1'b0);
    cmd(CMD_READ, 8'h00, 1'b1);
    `CHK({rdata_o, sniff, sniff_ack}, {tx_fn(n0), tx_fn(n0), 1'b0})
    cmd(CMD_READ, 8'h00, 1'b0);
    `CHK({rdata_o, sniff_ack}, {tx_fn(n0 + 1), 1'b1})
    cmd(CMD_STOP, 8'h00, 1'b0);
    repeat (5) @(negedge clock_i);
    `CHK({standby_o, write_busy_o}, 2'b10)
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, 8'($random(seed)), 1'b0);
    cmd(CMD_READ, 8'h00, 1'b1);
    tx_req_i = 1'b0;
    cmd(CMD_RECOVER, 8'h00, 1'b0);
    rx_q.delete();
    w0 = 8'($random(seed));
    w1 = 8'($random(seed));
    cmd(CMD_WRITE, w0, 1'b0);
    cmd(CMD_WRITE, w1, 1'b0);
    `CHK({rx_q.size() == 2, nack_o, rx_q[1]}, {2'b10, w1})
    busy_len = 0;
    cmd(CMD_STOP, 8'h00, 1'b0);
    wait_idle();
    `CHK(n_start, exp_start)
    `CHK(n_stop, exp_stop)
    give_verdict();
  end
endmodule
`default_nettype wire
